//--- design/dhit_timer.v
// What this block does
// - Reset sets both count halves and both load registers to all ones.
// - Reset clears both prescale registers to zero.
// - After reset everything is idle and nothing counts until enabled.
// - Config value 0 selects 32-bit one-shot/periodic, 1 selects 32-bit RTC; here RTC only holds the count.
// - In 32-bit one-shot/periodic mode a low load write fills high half too.
// - In 32-bit one-shot/periodic mode low count read returns high:low halves.
// - 32-bit mode acts as one timer; 16-bit halves run independently.
// - 32-bit mode takes one-shot/periodic from low mode field only.
// - Setting low enable with low mode one-shot or periodic starts counting down from the loaded value.
// - At zero the count reloads from the load value next cycle.
// - One-shot stops and clears enable at zero; periodic keeps counting.
// - At zero the raw timeout flag sets and holds until cleared.
// - Masked timeout flag follows raw flag when mask enables it.
// - At zero a trigger pulse is produced for other blocks.
// - A load write while running enters the counter next clock.
// - With stall set, debug halt freezes the count until resume.
// - Config value 4 selects 16-bit mode with separate halves.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dhit_regs.vh"

module dhit_timer
#(
  parameter HW = 16                          // Width of one half
)
(
  input  wire        pclk,                   // APB clock, 125 MHz
  input  wire        presetn,                // Async reset, active low
  input  wire        psel,                   // APB select
  input  wire        penable,                // APB access phase
  input  wire        pwrite,                 // APB write direction
  input  wire [11:0] paddr,                  // APB byte address
  input  wire [31:0] pwdata,                 // APB write data
  output wire        pready,                 // APB ready, always high
  output wire [31:0] prdata,                 // APB read data
  output wire        pslverr,                // APB error on unmapped address
  input  wire        debug_halt,             // Processor halted by debugger
  output wire        irq,                    // Level interrupt
  output wire        trig_low,               // Low half timeout trigger pulse
  output wire        trig_high               // High half timeout trigger pulse
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [2:0]    width_config_r;
  reg  [1:0]    lo_mode_r;
  reg  [1:0]    hi_mode_r;
  reg  [31:0]   ctrl_r;
  reg  [31:0]   irq_mask_r;
  reg  [31:0]   raw_stat_r;
  reg  [HW-1:0] lo_load_r;
  reg  [HW-1:0] hi_load_r;
  reg  [7:0]    lo_presc_r;
  reg  [7:0]    hi_presc_r;
  reg  [HW-1:0] lo_cnt_r;
  reg  [HW-1:0] hi_cnt_r;
  reg  [31:0]   prdata_r;
  reg           trig_lo_r;
  reg           trig_hi_r;

  reg  [31:0]   ctrl_nxt;
  reg  [31:0]   raw_stat_nxt;
  reg  [HW-1:0] lo_cnt_nxt;
  reg  [HW-1:0] hi_cnt_nxt;
  reg  [31:0]   rd_val;
  reg           rd_hit;
  reg           to_lo;
  reg           to_hi;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function valid_mode;
    input [1:0] m;
    begin
      valid_mode = (m == `DHIT_MODE_ONESHOT) || (m == `DHIT_MODE_PERIODIC);
    end
  endfunction

  wire          access   = psel & penable;
  wire          wr_en    = access & pwrite;
  wire          wr_cfg   = wr_en & (paddr == `DHIT_OFF_WIDTH_CFG);
  wire          wr_lmode = wr_en & (paddr == `DHIT_OFF_LO_MODE);
  wire          wr_hmode = wr_en & (paddr == `DHIT_OFF_HI_MODE);
  wire          wr_ctl   = wr_en & (paddr == `DHIT_OFF_CTRL);
  wire          wr_mask  = wr_en & (paddr == `DHIT_OFF_IRQ_MASK);
  wire          wr_clr   = wr_en & (paddr == `DHIT_OFF_IRQ_CLR);
  wire          wr_lld   = wr_en & (paddr == `DHIT_OFF_LO_LOAD);
  wire          wr_hld   = wr_en & (paddr == `DHIT_OFF_HI_LOAD);
  wire          wr_lpr   = wr_en & (paddr == `DHIT_OFF_LO_PRESC);
  wire          wr_hpr   = wr_en & (paddr == `DHIT_OFF_HI_PRESC);

  // Mode selection; RTC is only selectable, it holds the count
  wire          mode32   = (width_config_r == `DHIT_CFG_32_OSP);
  wire          mode16   = (width_config_r == `DHIT_CFG_16);

  wire [31:0]   cnt32    = {hi_cnt_r, lo_cnt_r};
  wire [31:0]   load32   = {hi_load_r, lo_load_r};
  wire [31:0]   msk_stat = raw_stat_r & irq_mask_r;

  // Stall only bites while the debugger really holds the core
  wire          lo_run   = ctrl_r[`DHIT_CTL_LO_EN] & valid_mode(lo_mode_r)
                           & ~(ctrl_r[`DHIT_CTL_LO_STALL] & debug_halt);
  wire          hi_run   = ctrl_r[`DHIT_CTL_HI_EN] & valid_mode(hi_mode_r)
                           & ~(ctrl_r[`DHIT_CTL_HI_STALL] & debug_halt);

  // ----------------------------------------
  // Counter next state
  // ----------------------------------------
  always @*
  begin
    ctrl_nxt   = ctrl_r;
    lo_cnt_nxt = lo_cnt_r;
    hi_cnt_nxt = hi_cnt_r;
    to_lo      = 1'b0;
    to_hi      = 1'b0;
    if (mode32)
    begin
      // High enable and high mode are ignored here
      if (lo_run)
      begin
        if (cnt32 == `DHIT_ZERO32)
        begin
          {hi_cnt_nxt, lo_cnt_nxt} = load32;
          to_lo = 1'b1;
          if (lo_mode_r == `DHIT_MODE_ONESHOT)
            ctrl_nxt[`DHIT_CTL_LO_EN] = 1'b0;
        end
        else
        begin
          {hi_cnt_nxt, lo_cnt_nxt} = cnt32 - `DHIT_ONE32;
        end
      end
    end
    else if (mode16)
    begin
      if (lo_run)
      begin
        if (lo_cnt_r == `DHIT_ZERO16)
        begin
          lo_cnt_nxt = lo_load_r;
          to_lo = 1'b1;
          if (lo_mode_r == `DHIT_MODE_ONESHOT)
            ctrl_nxt[`DHIT_CTL_LO_EN] = 1'b0;
        end
        else
        begin
          lo_cnt_nxt = lo_cnt_r - `DHIT_ONE16;
        end
      end
      if (hi_run)
      begin
        if (hi_cnt_r == `DHIT_ZERO16)
        begin
          hi_cnt_nxt = hi_load_r;
          to_hi = 1'b1;
          if (hi_mode_r == `DHIT_MODE_ONESHOT)
            ctrl_nxt[`DHIT_CTL_HI_EN] = 1'b0;
        end
        else
        begin
          hi_cnt_nxt = hi_cnt_r - `DHIT_ONE16;
        end
      end
    end
    // Software control write takes precedence over a one-shot auto clear
    if (wr_ctl)
      ctrl_nxt = pwdata & `DHIT_CTL_MASK;
    // A load write also lands in the counter on the next clock
    if (wr_lld)
    begin
      if (mode32)
        {hi_cnt_nxt, lo_cnt_nxt} = pwdata;
      else
        lo_cnt_nxt = pwdata[HW-1:0];
    end
    if (wr_hld)
      hi_cnt_nxt = pwdata[HW-1:0];
  end

  // Set beats clear so a timeout in the clearing cycle is kept
  always @*
  begin
    raw_stat_nxt = raw_stat_r;
    if (wr_clr)
      raw_stat_nxt = raw_stat_nxt & ~pwdata;
    if (to_lo)
      raw_stat_nxt[`DHIT_ST_LO_TO] = 1'b1;
    if (to_hi)
      raw_stat_nxt[`DHIT_ST_HI_TO] = 1'b1;
    raw_stat_nxt = raw_stat_nxt & `DHIT_ST_MASK;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    rd_val = `DHIT_ZERO32;
    rd_hit = 1'b1;
    case (paddr)
      `DHIT_OFF_WIDTH_CFG: rd_val = {29'h0000_0000, width_config_r};
      `DHIT_OFF_LO_MODE:   rd_val = {30'h0000_0000, lo_mode_r};
      `DHIT_OFF_HI_MODE:   rd_val = {30'h0000_0000, hi_mode_r};
      `DHIT_OFF_CTRL:      rd_val = ctrl_r;
      `DHIT_OFF_IRQ_MASK:  rd_val = irq_mask_r;
      `DHIT_OFF_RAW_STAT:  rd_val = raw_stat_r;
      `DHIT_OFF_MSK_STAT:  rd_val = msk_stat;
      `DHIT_OFF_IRQ_CLR:   rd_val = `DHIT_ZERO32;
      `DHIT_OFF_LO_LOAD:   rd_val = mode32 ? load32 : {16'h0000, lo_load_r};
      `DHIT_OFF_HI_LOAD:   rd_val = {16'h0000, hi_load_r};
      `DHIT_OFF_LO_PRESC:  rd_val = {24'h00_0000, lo_presc_r};
      `DHIT_OFF_HI_PRESC:  rd_val = {24'h00_0000, hi_presc_r};
      `DHIT_OFF_LO_COUNT:  rd_val = mode32 ? cnt32 : {16'h0000, lo_cnt_r};
      `DHIT_OFF_HI_COUNT:  rd_val = {16'h0000, hi_cnt_r};
      default:             rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      width_config_r <= `DHIT_CFG_32_OSP;
      lo_mode_r      <= 2'h0;
      hi_mode_r      <= 2'h0;
      ctrl_r         <= `DHIT_ZERO32;
      irq_mask_r     <= `DHIT_ZERO32;
      raw_stat_r     <= `DHIT_ZERO32;
      lo_load_r      <= `DHIT_RST_HALF;
      hi_load_r      <= `DHIT_RST_HALF;
      lo_cnt_r       <= `DHIT_RST_HALF;
      hi_cnt_r       <= `DHIT_RST_HALF;
      lo_presc_r     <= `DHIT_RST_PRESC;
      hi_presc_r     <= `DHIT_RST_PRESC;
      prdata_r       <= `DHIT_ZERO32;
      trig_lo_r      <= 1'b0;
      trig_hi_r      <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        width_config_r <= pwdata[2:0];
      if (wr_lmode)
        lo_mode_r <= pwdata[1:0];
      if (wr_hmode)
        hi_mode_r <= pwdata[1:0];
      if (wr_mask)
        irq_mask_r <= pwdata & `DHIT_ST_MASK;
      if (wr_lld)
        lo_load_r <= pwdata[HW-1:0];
      if (wr_lld && mode32)
        hi_load_r <= pwdata[31:16];
      else if (wr_hld)
        hi_load_r <= pwdata[HW-1:0];
      if (wr_lpr)
        lo_presc_r <= pwdata[7:0];
      if (wr_hpr)
        hi_presc_r <= pwdata[7:0];
      ctrl_r     <= ctrl_nxt;
      raw_stat_r <= raw_stat_nxt;
      lo_cnt_r   <= lo_cnt_nxt;
      hi_cnt_r   <= hi_cnt_nxt;
      trig_lo_r  <= to_lo;
      trig_hi_r  <= to_hi;
      // Captured in setup so the zero-wait access phase sees stable data
      if (psel && !penable && !pwrite)
        prdata_r <= rd_val;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready    = 1'b1;
  assign pslverr   = access & ~rd_hit;
  assign prdata    = prdata_r;
  assign irq       = |msk_stat;
  assign trig_low  = trig_lo_r;
  assign trig_high = trig_hi_r;

endmodule // dhit_timer

`default_nettype wire

//--- design/dhit_regs.vh
`ifndef DHIT_TIMER_REGS_VH
`define DHIT_TIMER_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DHIT_OFF_WIDTH_CFG   12'h000
`define DHIT_OFF_LO_MODE     12'h004
`define DHIT_OFF_HI_MODE     12'h008
`define DHIT_OFF_CTRL        12'h00c
`define DHIT_OFF_IRQ_MASK    12'h018
`define DHIT_OFF_RAW_STAT    12'h01c
`define DHIT_OFF_MSK_STAT    12'h020
`define DHIT_OFF_IRQ_CLR     12'h024
`define DHIT_OFF_LO_LOAD     12'h028
`define DHIT_OFF_HI_LOAD     12'h02c
`define DHIT_OFF_LO_PRESC    12'h038
`define DHIT_OFF_HI_PRESC    12'h03c
`define DHIT_OFF_LO_COUNT    12'h048
`define DHIT_OFF_HI_COUNT    12'h04c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DHIT_CTL_LO_EN       0
`define DHIT_CTL_LO_STALL    1
`define DHIT_CTL_HI_EN       8
`define DHIT_CTL_HI_STALL    9
`define DHIT_ST_LO_TO        0
`define DHIT_ST_HI_TO        8
`define DHIT_CTL_MASK        32'h0000_0303
`define DHIT_ST_MASK         32'h0000_0101

// ----------------------------------------
// Codes
// ----------------------------------------
`define DHIT_CFG_32_OSP      3'h0
`define DHIT_CFG_32_RTC      3'h1
`define DHIT_CFG_16          3'h4
`define DHIT_MODE_ONESHOT    2'h1
`define DHIT_MODE_PERIODIC   2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DHIT_RST_HALF        16'hffff
`define DHIT_RST_PRESC       8'h00
`define DHIT_ZERO32          32'h0000_0000
`define DHIT_ZERO16          16'h0000
`define DHIT_ONE32           32'h0000_0001
`define DHIT_ONE16           16'h0001

`endif

//--- bench/dhit_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dhit_mon (
  input wire logic        pclk,     // Clock
  input wire logic        presetn,  // Reset
  input wire logic        psel,     // Select
  input wire logic        penable,  // Access
  input wire logic        pwrite,   // Write
  input wire logic [11:0] paddr,    // Address
  input wire logic [31:0] pwdata,   // Data
  input wire logic        pslverr,  // Error
  input wire logic        irq,      // Interrupt
  input wire logic        trig_low, // Low trigger
  input wire logic        trig_high // High trigger
);
  // ----
  // Shadow of writes that gate outputs
  // ----
  logic [2:0] cfg_r;
  logic       msk_r;
  logic       wr_r;
  logic       en_r;
  wire        wr = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_r <= 3'h0;
      msk_r <= 1'h0;
      wr_r  <= 1'h0;
      en_r  <= 1'h0;
    end
    else if (wr)
    begin
      wr_r <= 1'h1;
      if (paddr == 12'h000)
        cfg_r <= pwdata[2:0];
      if (paddr == 12'h018)
        msk_r <= pwdata[0];
      if (paddr == 12'h00c && (pwdata[0] | pwdata[8]))
        en_r <= 1'h1;
    end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_unm; psel && penable && paddr == 12'h010 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_idle; !wr_r |-> !irq && !trig_low && !trig_high; endproperty
  a_idle: assert property (p_idle) else $error("active before writes");
  property p_dis; !en_r |-> !trig_low && !trig_high; endproperty
  a_dis: assert property (p_dis) else $error("trigger before enable");
  property p_up; $rose(irq) |-> trig_low || trig_high || $past(wr); endproperty
  a_up: assert property (p_up) else $error("irq rose alone");
  property p_dn; $fell(irq) |-> $past(wr); endproperty
  a_dn: assert property (p_dn) else $error("irq fell alone");
  property p_msk; trig_low && msk_r |-> irq; endproperty
  a_msk: assert property (p_msk) else $error("masked timeout lost");
  property p_hi; trig_high |-> cfg_r == 3'h4; endproperty
  a_hi: assert property (p_hi) else $error("high trigger outside split");
  property p_rtc; cfg_r == 3'h1 |-> !trig_low; endproperty
  a_rtc: assert property (p_rtc) else $error("counting in clock mode");
  c_lo: cover property (trig_low);
  c_hi: cover property (trig_high);
  c_clr: cover property ($fell(irq));
endmodule // dhit_mon

bind dhit_timer dhit_mon dhit_mon_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .irq(irq), .trig_low(trig_low), .trig_high(trig_high));
`default_nettype wire

//--- bench/dhit_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dhit_timer_tb;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, debug_halt, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, a;
  wire         pready, pslverr, irq, trig_low, trig_high;
  wire  [31:0] prdata;
  int          num_errors, samples_checked, cyc, g;
  logic [11:0] ra [11] = '{12'h000, 12'h004, 12'h00c, 12'h018, 12'h01c, 12'h028, 12'h02c,
                           12'h038, 12'h03c, 12'h048, 12'h04c};
  logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffffffff, 32'hffff,
                           32'h0, 32'h0, 32'hffffffff, 32'hffff};

  dhit_timer dhit_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq), .trig_low(trig_low),
    .trig_high(trig_high));

  initial
    forever #4 pclk = ~pclk;

  // Whole run needs well under 2000 cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // ----
  // Bus and check tasks
  // ----
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, v);
    samples_checked++;
    if (v !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask

  task xf(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [11:0] ad, input logic [31:0] d);
    xf(1'h1, ad, d);
  endtask

  task rc(input logic [11:0] ad, input logic [31:0] e);
    xf(1'h0, ad, 32'h0);
    chk($sformatf("reg %h", ad), e, rd);
  endtask

  // Two count reads three cycles apart, first kept in a
  task rr2;
    xf(1'h0, 12'h048, 32'h0);
    a = rd;
    xf(1'h0, 12'h048, 32'h0);
  endtask

  // Cycles between two trigger pulses, 200 when the second never comes
  // Sampled on the falling edge so the registered pulse has settled
  task gap(input logic hi);
    repeat (200)
      if ((hi ? trig_high : trig_low) !== 1'h1)
        @(negedge pclk);
    g = 0;
    do
    begin
      @(negedge pclk);
      g++;
    end
    while ((hi ? trig_high : trig_low) !== 1'h1 && g < 200);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, debug_halt} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ra[i])
      rc(ra[i], rv[i]);
    wr(12'h010, 32'h1);
    chk("error", 32'h1, err);
    wr(12'h028, 32'h0002_0003);
    rc(12'h02c, 32'h2);
    rc(12'h048, 32'h0002_0003);
    wr(12'h004, 32'h2);
    wr(12'h008, 32'h1);
    wr(12'h028, 32'h5);
    wr(12'h018, 32'h101);
    wr(12'h00c, 32'h1);
    gap(1'h0);
    chk("period", 32'h6, g);
    gap(1'h0);
    chk("period", 32'h6, g);
    chk("irq", 32'h1, irq);
    rc(12'h01c, 32'h1);
    rc(12'h020, 32'h1);
    wr(12'h028, 32'h1000);
    xf(1'h0, 12'h048, 32'h0);
    chk("reload", 32'h1, rd inside {[32'hff0:32'h1000]});
    wr(12'h00c, 32'h3);
    debug_halt <= 1'h1;
    rr2();
    chk("stall", a, rd);
    debug_halt <= 1'h0;
    rr2();
    chk("resume", 32'h3, a - rd);
    wr(12'h00c, 32'h0);
    rr2();
    chk("hold", a, rd);
    wr(12'h024, 32'h101);
    rc(12'h01c, 32'h0);
    chk("irq", 32'h0, irq);
    wr(12'h018, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h028, 32'h3);
    wr(12'h00c, 32'h1);
    gap(1'h0);
    chk("oneshot", 32'hc8, g);
    rc(12'h00c, 32'h0);
    rc(12'h01c, 32'h1);
    rc(12'h020, 32'h0);
    chk("irq", 32'h0, irq);
    wr(12'h024, 32'h1);
    wr(12'h000, 32'h4);
    wr(12'h008, 32'h2);
    wr(12'h02c, 32'h7);
    wr(12'h028, 32'h2);
    rc(12'h02c, 32'h7);
    wr(12'h00c, 32'h101);
    gap(1'h1);
    chk("period", 32'h8, g);
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h1);
    wr(12'h004, 32'h2);
    wr(12'h00c, 32'h1);
    gap(1'h0);
    chk("clock", 32'hc8, g);
    wr(12'h000, 32'h0);
    wr(12'h028, 32'h2);
    gap(1'h0);
    chk("period", 32'h3, g);
    give_verdict();
  end
endmodule // dhit_timer_tb
`default_nettype wire
